// *** src/esf_pkg.sv ***
package esf_pkg;
    // ---------------------------------------------
    // Exception kinds reported by the core
    // ---------------------------------------------
    typedef enum logic [1:0] {
        EK_ADDR_ERR,
        EK_INTERRUPT,
        EK_TRAP,
        EK_ILLEGAL
    } esf_kind_e;

    // One exception entry request
    typedef struct packed {
        esf_kind_e   kind;      // Exception kind
        logic        in_slot;   // Instruction sits in a delay slot
        logic        ldsr;      // Load-to-status-word form decoded
        logic [31:0] cur_pc;    // Address of faulting instruction
        logic [31:0] next_pc;   // Address of following instruction
        logic [31:0] branch_pc; // Address of the delayed branch
        logic [31:0] status;    // Status word to save
        logic [31:0] sp;        // Stack pointer at entry
        logic [31:0] vbase;     // Vector table base
    } esf_req_s;

    // ---------------------------------------------
    // Stacking constants
    // ---------------------------------------------
    localparam logic [31:0] STACK_STEP = 32'h0000_0004;
    localparam logic [1:0] LOW_BITS = 2'h3;

    // ---------------------------------------------
    // Register map (byte offsets)
    // ---------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_LAST_SP = 8'h0C;
    localparam logic [7:0] OFS_LAST_RET = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;
    localparam int EV_W = 4;
    localparam int EV_DONE = 0;
    localparam int EV_AERR = 1;
    localparam int EV_IGN = 2;
    localparam int EV_SLOT = 3;
    localparam logic CTRL_EN_RST = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Word-aligned form of an address
    function automatic logic [31:0] word_align(input logic [31:0] a);
        return {a[31:2], 2'h0};
    endfunction : word_align

    // True when an address is not a multiple of four
    function automatic logic misaligned(input logic [31:0] a);
        return (a[1:0] & LOW_BITS) != 2'h0;
    endfunction : misaligned
endpackage : esf_pkg

// *** src/esf_ret_sel.sv ***
`timescale 1ns/1ps
module esf_ret_sel
    import esf_pkg::*;
(
    input wire esf_req_s req_i,
    output logic [31:0] ret_o,
    output logic slot_ill_o
);
    // ---------------------------------------------
    // Return address choice per exception kind
    // ---------------------------------------------
    always_comb begin
        // Load-to-status in a slot counts as a slot illegal
        slot_ill_o = req_i.in_slot & (req_i.ldsr | (req_i.kind == EK_ILLEGAL));
        ret_o = req_i.cur_pc;
        unique case (req_i.kind)
            EK_ADDR_ERR: begin
                // Slot fault returns to the branch itself
                if (req_i.in_slot) begin
                    ret_o = req_i.branch_pc;
                end else begin
                    ret_o = req_i.cur_pc;
                end
            end
            EK_INTERRUPT: begin
                ret_o = req_i.next_pc;
            end
            EK_TRAP: begin
                ret_o = req_i.next_pc;
            end
            EK_ILLEGAL: begin
                ret_o = req_i.cur_pc;
            end
        endcase
        // Slot illegal stacks the delayed branch address
        if (slot_ill_o) begin
            ret_o = req_i.branch_pc;
        end
    end
endmodule : esf_ret_sel

// *** src/esf_irq.sv ***
`timescale 1ns/1ps
module esf_irq
    import esf_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [EV_W-1:0] ev_i,
    input wire logic [EV_W-1:0] clr_i,
    input wire logic [EV_W-1:0] mask_i,
    output logic [EV_W-1:0] status_o,
    output logic irq_o
);
    // ---------------------------------------------
    // Sticky status, set beats a same-cycle clear
    // ---------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_o <= '0;
        end else begin
            status_o <= (status_o & ~clr_i) | ev_i;
        end
    end

    // Level interrupt while any unmasked bit is set
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((status_o & ~clr_i) | ev_i) & mask_i);
        end
    end
endmodule : esf_irq

// *** src/esf_top.sv ***
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Contract
// - Push status first, then return address
// - Slot address error returns to branch
// - Other address error returns to faulting instruction
// - Interrupt returns to next instruction
// - Trap returns to instruction after trap
// - Slot illegal returns to delayed branch
// - General illegal returns to undefined instruction
// - Misaligned stack pointer flags an address error
// - Stacking error waits for frame end
// - Ignore errors while stacking an error frame
// - Faulting stack write still happens
// - Subtract four per pushed word
// - Bus address has low bits cleared
// - Load-to-status in slot is slot illegal
module esf_top
    import esf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire esf_req_s req_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [31:0] sp_o,
    output logic mem_valid_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_data_o,
    input wire logic mem_ready_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic irq_o
);
    // ---------------------------------------------
    // Elaboration checks
    // ---------------------------------------------
    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must cover the register map");
    end

    // ---------------------------------------------
    // State and storage
    // ---------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_PUSH_SR, ST_PUSH_RET} esf_state_e;
    esf_state_e st_q; // Stacking sequencer
    logic [31:0] sp_q; // Working stack pointer
    logic [31:0] start_sp_q; // Pointer at frame start
    logic [31:0] ret_q; // Return address to push
    logic [31:0] sr_q; // Status word to push
    logic aerr_frame_q; // Frame is for an address error
    logic aerr_pend_q; // Error waiting for frame end
    logic ctrl_en_q; // Software enable of entry
    logic [EV_W-1:0] mask_q; // Interrupt mask
    logic [EV_W-1:0] status; // Sticky event bits
    logic [EV_W-1:0] ev; // Event pulses this cycle
    logic [EV_W-1:0] clr; // Write-one-to-clear pulses
    logic [31:0] sel_ret; // Chosen return address
    logic sel_slot; // Slot illegal decision
    logic accept; // Request taken this edge
    logic mem_hs; // Stack write taken this edge
    logic sp_bad; // Entry pointer or base misaligned
    logic chain_bad; // Chained frame pointer misaligned

    assign accept = req_valid_i & req_ready_o;
    assign mem_hs = mem_valid_o & mem_ready_i;
    // Either alignment fault shows when the stack is touched
    assign sp_bad = misaligned(req_i.sp) | misaligned(req_i.vbase);
    // Still misaligned in a chain, since each push takes four
    assign chain_bad = misaligned(sp_q);

    // ---------------------------------------------
    // Return address selection
    // ---------------------------------------------
    esf_ret_sel u_sel (
        .req_i(req_i),
        .ret_o(sel_ret),
        .slot_ill_o(sel_slot)
    );

    // ---------------------------------------------
    // Stacking sequencer
    // ---------------------------------------------
    // Two writes per frame; a pending error chains a frame
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            sp_q <= '0;
            start_sp_q <= '0;
            ret_q <= '0;
            sr_q <= '0;
            aerr_frame_q <= 1'b0;
            aerr_pend_q <= 1'b0;
            req_ready_o <= 1'b0;
            done_o <= 1'b0;
            sp_o <= '0;
            mem_valid_o <= 1'b0;
            mem_addr_o <= '0;
            mem_data_o <= '0;
        end else begin
            done_o <= 1'b0;
            unique case (st_q)
                ST_IDLE: begin
                    req_ready_o <= ctrl_en_q & ~accept;
                    if (accept) begin
                        // First push is the status word
                        sp_q <= req_i.sp - STACK_STEP;
                        mem_addr_o <= word_align(req_i.sp - STACK_STEP);
                        mem_data_o <= req_i.status;
                        mem_valid_o <= 1'b1;
                        start_sp_q <= req_i.sp;
                        ret_q <= sel_ret;
                        sr_q <= req_i.status;
                        aerr_frame_q <= (req_i.kind == EK_ADDR_ERR) & ~sel_slot;
                        // Error frames never queue another one
                        aerr_pend_q <= sp_bad
                            & ~((req_i.kind == EK_ADDR_ERR) & ~sel_slot);
                        st_q <= ST_PUSH_SR;
                    end
                end
                ST_PUSH_SR: begin
                    if (mem_hs) begin
                        // Second push is the return address
                        sp_q <= sp_q - STACK_STEP;
                        mem_addr_o <= word_align(sp_q - STACK_STEP);
                        mem_data_o <= ret_q;
                        st_q <= ST_PUSH_RET;
                    end
                end
                ST_PUSH_RET: begin
                    if (mem_hs) begin
                        // Pointer now rests on the return word
                        done_o <= 1'b1;
                        sp_o <= sp_q;
                        if (aerr_pend_q) begin
                            // Address error entry only after this frame
                            aerr_pend_q <= 1'b0;
                            aerr_frame_q <= 1'b1;
                            start_sp_q <= sp_q;
                            sp_q <= sp_q - STACK_STEP;
                            mem_addr_o <= word_align(sp_q - STACK_STEP);
                            mem_data_o <= sr_q;
                            st_q <= ST_PUSH_SR;
                        end else begin
                            mem_valid_o <= 1'b0;
                            req_ready_o <= ctrl_en_q;
                            st_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------
    // Event pulses
    // ---------------------------------------------
    always_comb begin
        ev = '0;
        ev[EV_DONE] = (st_q == ST_PUSH_RET) & mem_hs;
        ev[EV_AERR] = accept & sp_bad;
        // Faults seen while an error frame stacks are dropped
        ev[EV_IGN] = (accept & sp_bad & (req_i.kind == EK_ADDR_ERR) & ~sel_slot)
            | ((st_q == ST_PUSH_RET) & mem_hs & aerr_pend_q & chain_bad);
        ev[EV_SLOT] = accept & sel_slot;
    end

    // Sticky event bits and the level interrupt
    esf_irq u_irq (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ev_i(ev),
        .clr_i(clr),
        .mask_i(mask_q),
        .status_o(status),
        .irq_o(irq_o)
    );

    // ---------------------------------------------
    // AXI4-Lite write channel
    // ---------------------------------------------
    logic wr_hs; // Address and data taken together
    logic [7:0] wofs; // Write offset
    assign wr_hs = s_axi_awready_o & s_axi_awvalid_i & s_axi_wvalid_i;
    assign wofs = s_axi_awaddr_i[7:0];

    // Ready pulses once both halves wait; response follows
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else begin
            if (wr_hs) begin
                s_axi_awready_o <= 1'b0;
                s_axi_wready_o <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                // Unmapped or read-only offsets answer an error
                s_axi_bresp_o <= (wofs == OFS_CTRL || wofs == OFS_STATUS
                    || wofs == OFS_MASK) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o) begin
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
            if (s_axi_bvalid_o & s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // Control and mask storage; low byte lane only
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_en_q <= CTRL_EN_RST;
            mask_q <= '0;
        end else if (wr_hs & s_axi_wstrb_i[0]) begin
            if (wofs == OFS_CTRL) begin
                ctrl_en_q <= s_axi_wdata_i[0];
            end
            if (wofs == OFS_MASK) begin
                mask_q <= s_axi_wdata_i[EV_W-1:0];
            end
        end
    end

    // Clear pulses for the sticky bits
    assign clr = (wr_hs & s_axi_wstrb_i[0] & (wofs == OFS_STATUS))
        ? s_axi_wdata_i[EV_W-1:0] : '0;

    // ---------------------------------------------
    // AXI4-Lite read channel
    // ---------------------------------------------
    logic rd_hs; // Read address taken
    logic [7:0] rofs; // Read offset
    assign rd_hs = s_axi_arready_o & s_axi_arvalid_i;
    assign rofs = s_axi_araddr_i[7:0];

    // Data is sampled at the address handshake
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else begin
            if (rd_hs) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= RESP_OKAY;
                unique case (rofs)
                    OFS_CTRL: s_axi_rdata_o <= {31'h0, ctrl_en_q};
                    OFS_STATUS: s_axi_rdata_o <= {28'h0, status};
                    OFS_MASK: s_axi_rdata_o <= {28'h0, mask_q};
                    OFS_LAST_SP: s_axi_rdata_o <= sp_o;
                    OFS_LAST_RET: s_axi_rdata_o <= ret_q;
                    OFS_STATE: s_axi_rdata_o <= {29'h0, aerr_pend_q,
                        aerr_frame_q, st_q != ST_IDLE};
                    default: begin
                        // Unmapped reads return zero with an error
                        s_axi_rdata_o <= '0;
                        s_axi_rresp_o <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_arvalid_i & ~s_axi_rvalid_o) begin
                s_axi_arready_o <= 1'b1;
            end
            if (s_axi_rvalid_o & s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Frame order and pushed data
    sr_first_a: assert property (accept |=> mem_valid_o
        && mem_data_o == $past(req_i.status))
        else $error("status word not pushed first");
    ret_second_a: assert property ((st_q == ST_PUSH_SR) && mem_hs |=> mem_data_o == ret_q)
        else $error("return address not pushed second");
    // Return address choice per kind
    slot_aerr_a: assert property (req_i.kind == EK_ADDR_ERR && req_i.in_slot
        |-> sel_ret == req_i.branch_pc)
        else $error("slot address error return wrong");
    plain_aerr_a: assert property (req_i.kind == EK_ADDR_ERR && !req_i.in_slot
        |-> sel_ret == req_i.cur_pc)
        else $error("address error return wrong");
    intr_ret_a: assert property (req_i.kind == EK_INTERRUPT && !sel_slot
        |-> sel_ret == req_i.next_pc)
        else $error("interrupt return wrong");
    slot_ret_a: assert property (sel_slot |-> sel_ret == req_i.branch_pc)
        else $error("slot illegal return wrong");
    ldsr_slot_a: assert property (req_i.in_slot && req_i.ldsr |-> sel_slot)
        else $error("load-to-status in slot not flagged");
    // Alignment faults and what follows them
    misalign_det_a: assert property (accept && misaligned(req_i.sp) |=> status[EV_AERR])
        else $error("misaligned pointer not detected");
    defer_err_a: assert property ($rose(aerr_pend_q) |-> mem_valid_o ##1 !done_o)
        else $error("frame aborted on stacking error");
    no_loop_a: assert property (aerr_frame_q |-> !aerr_pend_q)
        else $error("error queued during error frame");
    still_write_a: assert property (accept && sp_bad |=> mem_valid_o [*2])
        else $error("faulting stack write skipped");
    // Pointer steps; a chain reloads the start pointer at done
    sp_step_a: assert property (done_o |-> sp_o == $past(start_sp_q) - 32'h0000_0008)
        else $error("pointer not reduced by eight");
    addr_low_a: assert property (mem_valid_o |-> mem_addr_o == {sp_q[31:2], 2'h0})
        else $error("stack address not aligned");
    ret_top_a: assert property ((st_q == ST_PUSH_RET)
        |-> mem_addr_o[31:2] == sp_q[31:2] && sp_q == start_sp_q - 32'h0000_0008)
        else $error("return word not at final pointer");

    // ---------------------------------------------
    // Scenarios worth seeing
    // ---------------------------------------------
    chain_c: cover property (aerr_pend_q && done_o);
    intr_c: cover property (accept && req_i.kind == EK_INTERRUPT);
    slot_c: cover property (accept && sel_slot);
    irq_c: cover property ($rose(irq_o));
    ign_c: cover property (ev[EV_IGN]);
endmodule : esf_top

// *** test/esf_mem_model.sv ***
`timescale 1ns/1ps
module esf_mem_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic mem_valid_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_data_i,
    output logic mem_ready_o
);
    // ---------------------------------------------
    // Stack memory stand-in
    // ---------------------------------------------
    logic [31:0] addr_log[$]; // Taken write addresses
    logic [31:0] data_log[$]; // Taken write data

    // Ready steady when prompt, every other cycle when slow
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_ready_o <= 1'b0;
        end else begin
            mem_ready_o <= slow_i ? ~mem_ready_o : 1'b1;
        end
    end

    // Log a write only at the edge that takes it
    always @(posedge core_clk_i) begin
        if (!rst_i && mem_valid_i === 1'b1 && mem_ready_o === 1'b1) begin
            addr_log.push_back(mem_addr_i);
            data_log.push_back(mem_data_i);
        end
    end
endmodule : esf_mem_model

// *** test/esf_top_tb.sv ***
`timescale 1ns/1ps
module esf_top_tb
    import esf_pkg::*;
;
    // ---------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    esf_req_s req_i = '0;
    logic slow = 1'b0; // Memory stalls when set
    logic req_ready_o, done_o, mem_valid_o, mem_ready_i, irq_o;
    logic [31:0] sp_o, mem_addr_o, mem_data_o;
    logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
    logic aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
    logic [31:0] w_d = 32'h0000_0000;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_d;
    int bad_count = 0;
    int n_compared = 0;
    int done_cnt = 0; // Frames finished so far
    int cyc = 0;

    always #2.5 core_clk_i = ~core_clk_i;

    esf_top #(.ADDR_W(8)) i_esf_top (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .done_o(done_o), .sp_o(sp_o), .mem_valid_o(mem_valid_o),
        .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .mem_ready_i(mem_ready_i),
        .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy),
        .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_v),
        .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v),
        .s_axi_bready_i(b_rdy), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
        .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp),
        .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_rdy), .irq_o(irq_o));

    esf_mem_model i_esf_mem_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow),
        .mem_valid_i(mem_valid_o), .mem_addr_i(mem_addr_o), .mem_data_i(mem_data_o),
        .mem_ready_o(mem_ready_i));

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    // Count finished frames, chained ones included
    always @(posedge core_clk_i) begin
        if (done_o === 1'b1) begin
            done_cnt++;
        end
    end

    // Hang guard, far beyond the expected run
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_rdy <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge core_clk_i);
            if (!ad && aw_rdy === 1'b1) begin
                ad = 1'b1;
                aw_v <= 1'b0;
            end
            if (!wd && w_rdy === 1'b1) begin
                wd = 1'b1;
                w_v <= 1'b0;
            end
        end
        while (b_v !== 1'b1) @(posedge core_clk_i);
        chk("bresp", {30'h0, er}, {30'h0, b_resp});
        b_rdy <= 1'b0;
        @(posedge core_clk_i); // Keeps two drives of one signal apart
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        ar_a <= a;
        ar_v <= 1'b1;
        r_rdy <= 1'b1;
        do @(posedge core_clk_i); while (ar_rdy !== 1'b1);
        ar_v <= 1'b0;
        while (r_v !== 1'b1) @(posedge core_clk_i);
        chk("rdata", e, r_d);
        chk("rresp", {30'h0, er}, {30'h0, r_resp});
        r_rdy <= 1'b0;
        @(posedge core_clk_i);
    endtask : axi_rd

    // One exception entry, then the stacked frame(s) against expectation
    task automatic run_case(input esf_kind_e k, input logic sl, input logic ld,
        input logic [31:0] sp, input logic [31:0] vb, input logic [31:0] ret,
        input int fr, input logic [3:0] st);
        esf_req_s r;
        int n0, d0;
        logic rdy;
        r = '{kind: k, in_slot: sl, ldsr: ld, cur_pc: 32'h0000_1000,
            next_pc: 32'h0000_1002, branch_pc: 32'h0000_0FFE,
            status: 32'h0000_00F0, sp: sp, vbase: vb};
        axi_wr(OFS_STATUS, 32'h0000_000F, RESP_OKAY);
        n0 = i_esf_mem_model.addr_log.size();
        d0 = done_cnt;
        req_i <= r;
        req_valid_i <= 1'b1;
        do begin
            @(negedge core_clk_i);
            rdy = req_ready_o;
            @(posedge core_clk_i);
        end while (rdy !== 1'b1);
        req_valid_i <= 1'b0;
        while (done_cnt < d0 + fr) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk("sp", sp - 32'(8 * fr), sp_o);
        chk("writes", 32'(2 * fr), 32'(i_esf_mem_model.addr_log.size() - n0));
        for (int i = 0; i < 2 * fr; i++) begin
            logic [31:0] ea;
            ea = sp - 32'(4 * (i + 1));
            chk("addr", {ea[31:2], 2'h0}, i_esf_mem_model.addr_log[n0 + i]);
            // Data of a misaligned push is undefined, so only aligned ones compare
            if (sp[1:0] == 2'h0) begin
                chk("data", (i % 2 == 0) ? r.status : ret, i_esf_mem_model.data_log[n0 + i]);
            end
        end
        axi_rd(OFS_STATUS, {28'h0, st}, RESP_OKAY);
        axi_rd(OFS_LAST_RET, ret, RESP_OKAY);
        axi_rd(OFS_LAST_SP, sp - 32'(8 * fr), RESP_OKAY);
    endtask : run_case

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        axi_rd(OFS_CTRL, {31'h0, CTRL_EN_RST}, RESP_OKAY);
        axi_rd(OFS_MASK, 32'h0000_0000, RESP_OKAY);
        axi_rd(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
        axi_rd(8'h20, 32'h0000_0000, RESP_SLVERR); // Unmapped place
        axi_wr(8'h20, 32'h0000_0001, RESP_SLVERR);
        axi_wr(OFS_LAST_SP, 32'h0000_0001, RESP_SLVERR); // Read-only place
        // Disabled unit refuses requests
        axi_wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
        repeat (2) @(posedge core_clk_i);
        chk("ready_off", 32'h0, {31'h0, req_ready_o});
        axi_wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
        run_case(EK_ADDR_ERR, 1'b1, 1'b0, 32'h0000_2000, 32'h0, 32'h0000_0FFE, 1, 4'h1);
        // Interrupt masked, unmasked, then cleared
        chk("irq_masked", 32'h0, {31'h0, irq_o});
        axi_wr(OFS_MASK, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(posedge core_clk_i);
        chk("irq_on", 32'h1, {31'h0, irq_o});
        axi_wr(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(posedge core_clk_i);
        chk("irq_off", 32'h0, {31'h0, irq_o});
        run_case(EK_ADDR_ERR, 1'b0, 1'b0, 32'h0000_2000, 32'h0, 32'h0000_1000, 1, 4'h1);
        slow <= 1'b1;
        run_case(EK_INTERRUPT, 1'b0, 1'b0, 32'h0000_2000, 32'h0, 32'h0000_1002, 1, 4'h1);
        run_case(EK_TRAP, 1'b0, 1'b0, 32'h0000_2000, 32'h0, 32'h0000_1002, 1, 4'h1);
        slow <= 1'b0;
        run_case(EK_ILLEGAL, 1'b1, 1'b0, 32'h0000_2000, 32'h0, 32'h0000_0FFE, 1, 4'h9);
        run_case(EK_ILLEGAL, 1'b0, 1'b0, 32'h0000_2000, 32'h0, 32'h0000_1000, 1, 4'h1);
        run_case(EK_TRAP, 1'b1, 1'b1, 32'h0000_2000, 32'h0, 32'h0000_0FFE, 1, 4'h9);
        // Misaligned pointer: frame ends, then a chained frame whose fault is ignored
        run_case(EK_INTERRUPT, 1'b0, 1'b0, 32'h0000_2002, 32'h0, 32'h0000_1002, 2, 4'h7);
        // Misaligned table base is caught the same way
        run_case(EK_TRAP, 1'b0, 1'b0, 32'h0000_2000, 32'h0000_0102, 32'h0000_1002, 2, 4'h3);
        // Error frame with bad pointer: detected, ignored, no chain
        run_case(EK_ADDR_ERR, 1'b0, 1'b0, 32'h0000_2001, 32'h0, 32'h0000_1000, 1, 4'h7);
        axi_rd(OFS_STATE, 32'h0000_0002, RESP_OKAY);
        summarize();
    end
endmodule : esf_top_tb
